// ===== design/standby_wakeup_source_detector.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A lane's 3-bit mode selects low, high, fall, rise or both edges; 101-111 detect nothing.
// - Each lane has a read-only 2-bit edge status: 01 rising, 10 falling, 11 both.
// - The edge status is set only while the lane is in both-edge mode.
// - Clearing a lane's request through the clear register also clears its edge status.
// - A lane's enable bit lets its pending request release standby; zero blocks it.
// - A lane byte holds mode at 6-4, status at 3-2, enable at 0; A has lanes 0-3, B 4-5.
// - Writing code 0 to 5 to the clear register clears that lane; other codes do nothing.
module standby_wakeup_source_detector (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [wake_pkg::ADDR_W-1:0] address_i,
  input wire logic [wake_pkg::DATA_W-1:0] write_data_i,
  input wire logic write_strobe_i,
  input wire logic read_strobe_i,
  output logic [wake_pkg::DATA_W-1:0] read_data_o,
  input wire logic low_voltage_wake_event_i,
  input wire logic [3:0] external_wake_line_i,
  input wire logic clock_calendar_wake_event_i,
  output logic wake_request_o,
  output logic [wake_pkg::LANES-1:0] wake_pending_o
);
  import wake_pkg::*;

  typedef struct packed {
    logic [LANES-1:0] sync1;
    logic [LANES-1:0] sync2;
    logic [LANES-1:0] sync3;
    logic [LANES-1:0] filt;
    logic [LANES-1:0][MODE_W-1:0] mode;
    logic [LANES-1:0] enable;
    logic [DATA_W-1:0] rdata;
    logic wake;
    logic [LANES-1:0] pend_out;
  } top_state_s;

  localparam top_state_s TOP_RESET = '{
    sync1: '0, sync2: '0, sync3: '0, filt: '0,
    mode: {LANES{MODE_RESET}},
    enable: {LANES{ENABLE_RESET}},
    rdata: '0, wake: 1'b0, pend_out: '0
  };

  top_state_s q;
  top_state_s d;
  logic [LANES-1:0] sources;
  logic [LANES-1:0] lane_pending;
  logic [LANES-1:0][STATUS_W-1:0] lane_status;
  logic [LANES-1:0] clear_vec;
  logic [DATA_W-1:0] read_word;
  logic sel_a;
  logic sel_b;
  logic sel_clear;

  // ==========================================================
  // Helpers
  function automatic logic [LANE_W-1:0] lane_byte(input mode_t m, input status_t s, input logic e);
    logic [LANE_W-1:0] b;
    b = '0;
    b[MODE_LSB +: MODE_W] = m;
    b[STATUS_LSB +: STATUS_W] = s;
    b[ENABLE_BIT] = e;
    return b;
  endfunction : lane_byte

  function automatic int unsigned lane_slot(input int unsigned lane);
    return (lane < LANES_A) ? lane : lane - LANES_A;
  endfunction : lane_slot

  assign sources = {clock_calendar_wake_event_i, external_wake_line_i, low_voltage_wake_event_i};
  assign sel_a = (address_i == ADDR_MODE_A);
  assign sel_b = (address_i == ADDR_MODE_B);
  assign sel_clear = (address_i == ADDR_CLEAR);

  // ==========================================================
  // Register read mux
  always_comb begin
    read_word = '0;
    if (sel_a) begin
      for (int unsigned i = 0; i < LANES_A; i++) begin
        read_word[i*LANE_W +: LANE_W] =
          lane_byte(q.mode[i], lane_status[i], q.enable[i]);
      end
    end else if (sel_b) begin
      for (int unsigned i = LANES_A; i < LANES; i++) begin
        read_word[lane_slot(i)*LANE_W +: LANE_W] =
          lane_byte(q.mode[i], lane_status[i], q.enable[i]);
      end
    end
  end

  // ==========================================================
  // Clear decode
  always_comb begin
    for (int unsigned i = 0; i < LANES; i++) begin
      clear_vec[i] = write_strobe_i && sel_clear &&
        (write_data_i[CLEAR_W-1:0] == CLEAR_W'(i));
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.sync1 = sources;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    for (int unsigned i = 0; i < LANES; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        d.filt[i] = q.sync3[i];
      end
    end
    // Mode and enable only; status bits are read-only
    for (int unsigned i = 0; i < LANES; i++) begin
      if (write_strobe_i && ((i < LANES_A) ? sel_a : sel_b)) begin
        d.mode[i] = write_data_i[lane_slot(i)*LANE_W + MODE_LSB +: MODE_W];
        d.enable[i] = write_data_i[lane_slot(i)*LANE_W + ENABLE_BIT];
      end
    end
    d.rdata = read_strobe_i ? read_word : '0;
    // Mode and enable change in the same write, so enable can meet a request latched under the old mode
    d.wake = |(lane_pending & q.enable);
    d.pend_out = lane_pending;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= TOP_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Lanes
  // Lane k watches source bit k: 0 low voltage, 1-4 external lines, 5 clock calendar
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    wake_lane_if lane_bus ();
    assign lane_bus.mode = q.mode[g];
    assign lane_bus.level = q.filt[g];
    assign lane_bus.clear = clear_vec[g];
    assign lane_pending[g] = lane_bus.pending;
    assign lane_status[g] = lane_bus.status;
    wake_lane u_lane (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .bus(lane_bus)
    );
  end

  assign read_data_o = q.rdata;
  assign wake_request_o = q.wake;
  assign wake_pending_o = q.pend_out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_read_a;
    read_strobe_i && sel_a;
  endsequence
  sequence s_write_a;
    write_strobe_i && sel_a;
  endsequence

  a_wake_gate_on: assert property (|(lane_pending & q.enable) |=> wake_request_o)
    else $error("enabled request did not release standby");
  a_wake_gate_off: assert property (!(|(lane_pending & q.enable)) |=> !wake_request_o)
    else $error("standby released without enabled request");
  a_read_lane_mode: assert property (s_read_a |=> read_data_o[MODE_LSB +: MODE_W] ==
    $past(q.mode[0]))
    else $error("lane mode misplaced on read");
  a_write_enable: assert property (s_write_a |=>
    q.enable[1] == $past(write_data_i[LANE_W]))
    else $error("enable write lost");
  a_unused_zero: assert property ((read_data_o & UNUSED_MASK) == '0)
    else $error("unused bit reads nonzero");
  a_read_b_upper: assert property (read_strobe_i && sel_b |=> read_data_o[31:16] == '0)
    else $error("upper half of B nonzero");
  a_read_idle: assert property (!read_strobe_i |=> read_data_o == '0)
    else $error("read data outside read slot");
  a_clear_onehot: assert property ($onehot0(clear_vec))
    else $error("clear hit more than one lane");
  a_clear_illegal: assert property (write_strobe_i && sel_clear &&
    (write_data_i[CLEAR_W-1:0] > CLEAR_LAST) |-> clear_vec == '0)
    else $error("prohibited clear code acted");
  a_filter_agree: assert property (q.sync2[1] == q.sync3[1] |=> q.filt[1] == $past(q.sync3[1]))
    else $error("filter missed agreed sample");
  a_filter_hold: assert property (q.sync2[0] != q.sync3[0] |=> q.filt[0] == $past(q.filt[0]))
    else $error("filter took a disputed sample");

  // ==========================================================
  // Lane B, edge status read, write isolation and last clear code checks
  sequence s_read_b;
    read_strobe_i && sel_b;
  endsequence
  sequence s_write_b;
    write_strobe_i && sel_b;
  endsequence

  a_write_mode_b: assert property (s_write_b |=>
    q.mode[LANES_A] == $past(write_data_i[MODE_LSB +: MODE_W]))
    else $error("lane mode write to B lost");
  a_read_enable_b: assert property (s_read_b |=>
    read_data_o[LANE_W + ENABLE_BIT] == $past(q.enable[LANES-1]))
    else $error("clock-calendar enable misplaced on read");
  a_read_status: assert property (s_read_a |=>
    read_data_o[STATUS_LSB +: STATUS_W] == $past(lane_status[0]))
    else $error("edge status misplaced on read");
  a_write_hold: assert property (!(write_strobe_i && (sel_a || sel_b)) |=>
    $stable(q.mode) && $stable(q.enable))
    else $error("mode or enable changed without a write");
  a_clear_last: assert property (write_strobe_i && sel_clear &&
    (write_data_i[CLEAR_W-1:0] == CLEAR_LAST) |-> clear_vec[LANES-1])
    else $error("last clear code missed its lane");
endmodule : standby_wakeup_source_detector
`default_nettype wire

// ===== design/wake_pkg.sv
package wake_pkg;
  // ==========================================================
  // Geometry
  localparam int unsigned LANES = 6;
  localparam int unsigned LANES_A = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned STATUS_W = 2;
  localparam int unsigned CLEAR_W = 5;
  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_MODE_A = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MODE_B = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'h08;
  // ==========================================================
  // Field positions inside one byte lane
  localparam int unsigned MODE_LSB = 4;
  localparam int unsigned STATUS_LSB = 2;
  localparam int unsigned ENABLE_BIT = 0;
  localparam logic [DATA_W-1:0] UNUSED_MASK = 32'h82828282;
  // ==========================================================
  // Detection modes and edge status codes
  typedef logic [MODE_W-1:0] mode_t;
  typedef logic [STATUS_W-1:0] status_t;
  localparam mode_t MODE_LOW = 3'h0;
  localparam mode_t MODE_HIGH = 3'h1;
  localparam mode_t MODE_FALL = 3'h2;
  localparam mode_t MODE_RISE = 3'h3;
  localparam mode_t MODE_BOTH = 3'h4;
  localparam status_t STATUS_NONE = 2'h0;
  localparam status_t STATUS_RISE = 2'h1;
  localparam status_t STATUS_FALL = 2'h2;
  localparam logic [CLEAR_W-1:0] CLEAR_LAST = 5'h05;
  // ==========================================================
  // Reset values
  localparam mode_t MODE_RESET = MODE_FALL;
  localparam logic ENABLE_RESET = 1'b0;
endpackage : wake_pkg

// ===== design/wake_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wake_lane_if;
  import wake_pkg::*;
  mode_t mode;
  logic level;
  logic clear;
  logic pending;
  status_t status;
  modport ctrl (output mode, output level, output clear, input pending, input status);
  modport lane (input mode, input level, input clear, output pending, output status);
endinterface : wake_lane_if
`default_nettype wire

// ===== design/wake_lane.sv
`timescale 1ns/1ps
`default_nettype none
module wake_lane (
  input wire logic clock_i,
  input wire logic rst_b_i,
  wake_lane_if.lane bus
);
  import wake_pkg::*;

  typedef struct packed {
    logic armed;
    logic prev;
    logic pending;
    status_t status;
  } lane_state_s;

  lane_state_s q;
  lane_state_s d;
  logic rise;
  logic fall;
  logic hit;

  // ==========================================================
  // Detection
  always_comb begin
    d = q;
    // First sample after reset only primes the edge history
    rise = q.armed && !q.prev && bus.level;
    fall = q.armed && q.prev && !bus.level;
    unique case (bus.mode)
      MODE_LOW: hit = q.armed && !bus.level;
      MODE_HIGH: hit = q.armed && bus.level;
      MODE_FALL: hit = fall;
      MODE_RISE: hit = rise;
      MODE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
    d.armed = 1'b1;
    d.prev = bus.level;
    if (bus.clear) begin
      d.pending = 1'b0;
      d.status = STATUS_NONE;
    end
    // Set wins over clear
    if (hit) begin
      d.pending = 1'b1;
    end
    if (bus.mode == MODE_BOTH) begin
      if (rise) begin
        d.status = d.status | STATUS_RISE;
      end
      if (fall) begin
        d.status = d.status | STATUS_FALL;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{armed: 1'b0, prev: 1'b0, pending: 1'b0, status: STATUS_NONE};
    end else begin
      q <= d;
    end
  end

  assign bus.pending = q.pending;
  assign bus.status = q.status;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_rise;
    q.armed && !q.prev && bus.level;
  endsequence
  sequence s_fall;
    q.armed && q.prev && !bus.level;
  endsequence

  a_both_rise_flag: assert property ((bus.mode == MODE_BOTH) ##0 s_rise |=> q.status[0])
    else $error("rising edge not recorded");
  a_both_fall_flag: assert property ((bus.mode == MODE_BOTH) ##0 s_fall |=> q.status[1])
    else $error("falling edge not recorded");
  a_status_only_both: assert property (
    (bus.mode != MODE_BOTH) && (q.status == STATUS_NONE) |=> q.status == STATUS_NONE)
    else $error("edge status set outside both-edge mode");
  a_clear_status: assert property (bus.clear && !hit |=>
    q.status == STATUS_NONE && !q.pending)
    else $error("clear left status or request");
  a_low_level_hit: assert property ((bus.mode == MODE_LOW) && q.armed && !bus.level
    |=> q.pending)
    else $error("low level not detected");
  a_illegal_mode: assert property ((bus.mode > MODE_BOTH) && !q.pending |=> !q.pending)
    else $error("prohibited mode raised a request");
endmodule : wake_lane
`default_nettype wire

// ===== verification/wake_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  input wire logic clock_i,
  input wire logic [5:0] level_i,
  output logic low_voltage_wake_event_o,
  output logic [3:0] external_wake_line_o,
  output logic clock_calendar_wake_event_o
);
  // ==========================================================
  // Source levels, changed only just after a rising edge
  logic [5:0] level_q = 6'h00;
  always @(posedge clock_i) begin
    level_q <= level_i;
  end
  assign low_voltage_wake_event_o = level_q[0];
  assign external_wake_line_o = level_q[4:1];
  assign clock_calendar_wake_event_o = level_q[5];
endmodule : wake_source_model
`default_nettype wire

// ===== verification/standby_wakeup_source_detector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module standby_wakeup_source_detector_tb_top;
  import wake_pkg::*;
  localparam int SETTLE = 10;
  localparam int LIMIT = 5000;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic ws = 1'b0;
  logic rs = 1'b0;
  logic [31:0] rdata;
  logic [5:0] src = 6'h00;
  logic lvd;
  logic [3:0] ext;
  logic rtc;
  logic req;
  logic [5:0] pend_o;
  int n_errors = 0;
  int tests_run = 0;
  // ==========================================================
  // Design and source model
  standby_wakeup_source_detector i_standby_wakeup_source_detector (
    .clock_i(clock), .rst_b_i(rst_b), .address_i(address), .write_data_i(wdata),
    .write_strobe_i(ws), .read_strobe_i(rs), .read_data_o(rdata),
    .low_voltage_wake_event_i(lvd), .external_wake_line_i(ext),
    .clock_calendar_wake_event_i(rtc), .wake_request_o(req), .wake_pending_o(pend_o));
  wake_source_model i_wake_source_model (
    .clock_i(clock), .level_i(src), .low_voltage_wake_event_o(lvd),
    .external_wake_line_o(ext), .clock_calendar_wake_event_o(rtc));
  initial begin
    forever #10 clock = ~clock;
  end
  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    ws <= 1'b1;
    address <= a;
    wdata <= d;
    @(posedge clock);
    ws <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rs <= 1'b1;
    address <= a;
    @(posedge clock);
    rs <= 1'b0;
    #1;
    check("read_data", rdata, exp);
    cyc(1);
    check("read_idle", rdata, 32'h0);
  endtask : rd
  task automatic pend(input logic [5:0] p, input logic r);
    check("pending", {26'h0, pend_o}, {26'h0, p});
    check("request", {31'h0, req}, {31'h0, r});
  endtask : pend
  task automatic clr(input logic [4:0] c);
    wr(ADDR_CLEAR, {27'h0, c});
    cyc(3);
  endtask : clr
  task automatic try_mode(input mode_t m, input logic b, input logic a, input logic e);
    logic [7:0] lane;
    lane = {1'b0, m, 4'h0};
    wr(ADDR_MODE_B, {16'h0, 8'h20, lane});
    src[4] <= b;
    cyc(SETTLE);
    clr(5'h04);
    src[4] <= a;
    cyc(SETTLE);
    check("mode_pending", {31'h0, pend_o[4]}, {31'h0, e});
    if (m == MODE_BOTH) lane[3:2] = a ? STATUS_RISE : STATUS_FALL;
    rd(ADDR_MODE_B, {16'h0, 8'h20, lane});
  endtask : try_mode
  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    cyc(2);
    rd(ADDR_MODE_A, 32'h20202020);
    rd(ADDR_MODE_B, 32'h00002020);
    rd(8'h0C, 32'h0);
    rd(ADDR_CLEAR, 32'h0);
    pend(6'h00, 1'b0);
    $display("test reset done");
    wr(ADDR_MODE_A, 32'h4E4E4E3E);
    rd(ADDR_MODE_A, 32'h40404030);
    wr(ADDR_MODE_B, 32'h70702E4E);
    rd(ADDR_MODE_B, 32'h00002040);
    wr(ADDR_MODE_A, 32'h4F4F4F3F);
    rd(ADDR_MODE_A, 32'h41414131);
    wr(ADDR_MODE_B, 32'h70702F4F);
    rd(ADDR_MODE_B, 32'h00002141);
    $display("test registers done");
    src[1] <= 1'b1;
    cyc(SETTLE);
    pend(6'h02, 1'b1);
    rd(ADDR_MODE_A, 32'h41414531);
    src[1] <= 1'b0;
    cyc(SETTLE);
    rd(ADDR_MODE_A, 32'h41414D31);
    clr(5'h01);
    pend(6'h00, 1'b0);
    rd(ADDR_MODE_A, 32'h41414131);
    $display("test both edges done");
    wr(ADDR_MODE_A, 32'h40404030);
    src[2] <= 1'b1;
    cyc(SETTLE);
    pend(6'h04, 1'b0);
    wr(ADDR_MODE_A, 32'h41414131);
    cyc(3);
    pend(6'h04, 1'b1);
    clr(5'h02);
    pend(6'h00, 1'b0);
    $display("test enable done");
    src[0] <= 1'b1;
    src[5] <= 1'b1;
    cyc(SETTLE);
    src[5] <= 1'b0;
    cyc(SETTLE);
    pend(6'h21, 1'b1);
    clr(5'h06);
    clr(5'h1F);
    pend(6'h21, 1'b1);
    clr(5'h00);
    pend(6'h20, 1'b1);
    clr(5'h05);
    pend(6'h00, 1'b0);
    $display("test clear codes done");
    try_mode(MODE_LOW, 1'b1, 1'b0, 1'b1);
    try_mode(MODE_HIGH, 1'b0, 1'b1, 1'b1);
    try_mode(MODE_FALL, 1'b1, 1'b0, 1'b1);
    try_mode(MODE_FALL, 1'b0, 1'b1, 1'b0);
    try_mode(MODE_RISE, 1'b0, 1'b1, 1'b1);
    try_mode(MODE_RISE, 1'b1, 1'b0, 1'b0);
    try_mode(MODE_BOTH, 1'b1, 1'b0, 1'b1);
    try_mode(MODE_BOTH, 1'b0, 1'b1, 1'b1);
    try_mode(3'h5, 1'b0, 1'b1, 1'b0);
    $display("test modes done");
    @(posedge clock);
    rst_b <= 1'b0;
    cyc(3);
    pend(6'h00, 1'b0);
    @(posedge clock);
    rst_b <= 1'b1;
    cyc(2);
    rd(ADDR_MODE_A, 32'h20202020);
    rd(ADDR_MODE_B, 32'h00002020);
    pend(6'h00, 1'b0);
    $display("test second reset done");
    end_of_test();
  end
  // Tests need well under a thousand cycles
  initial begin
    repeat (LIMIT) @(posedge clock);
    n_errors++;
    end_of_test();
  end
endmodule : standby_wakeup_source_detector_tb_top
`default_nettype wire
